// File: hdl/ddc_nco_phase_registers.sv
// How it works
// - select codes 1100-1111 pick channels 12-15
// - phase control bits 3:0 name update channel
// - update continuous or on transfer command
// - index codes 0000-0011 target channels 0-3
// - tuning word is signed two's complement
// - frequency equals word times rate over 2^48
// - tuning word in six bytes, lsb lowest
// - phase offset in six bytes, lsb first
// - edge mode 1000 counts channel_a_gpio_pin0 rises
// - edge counter wraps after select field value
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "nco_phase_cfg.svh"

module ddc_nco_phase_registers
	import nco_phase_pkg::*;
(
	input  wire logic                 ref_clk_i,
	input  wire logic                 srst_i,
	input  wire logic [`ADDR_W-1:0]   awaddr_i,
	input  wire logic                 awvalid_i,
	output logic                      awready_o,
	input  wire logic [31:0]          wdata_i,
	input  wire logic [3:0]           wstrb_i,
	input  wire logic                 wvalid_i,
	output logic                      wready_o,
	output logic [1:0]                bresp_o,
	output logic                      bvalid_o,
	input  wire logic                 bready_i,
	input  wire logic [`ADDR_W-1:0]   araddr_i,
	input  wire logic                 arvalid_i,
	output logic                      arready_o,
	output logic [31:0]               rdata_o,
	output logic [1:0]                rresp_o,
	output logic                      rvalid_o,
	input  wire logic                 rready_i,
	input  wire logic                 channel_a_gpio_pin0_i,
	output logic [`PHASE_W-1:0]       nco_phase_o,
	output logic [`CHAN_W-1:0]        nco_channel_o
);

	localparam logic [11:0] TW_IDX [`NUM_BYTES] = '{
		`IDX_TW_BYTE0, `IDX_TW_BYTE1, `IDX_TW_BYTE2,
		`IDX_TW_BYTE3, `IDX_TW_BYTE4, `IDX_TW_BYTE5
	};
	localparam logic [11:0] PO_IDX [`NUM_BYTES] = '{
		`IDX_PO_BYTE0, `IDX_PO_BYTE1, `IDX_PO_BYTE2,
		`IDX_PO_BYTE3, `IDX_PO_BYTE4, `IDX_PO_BYTE5
	};

	// bus slave state
	logic            aw_held;
	logic            w_held;
	wr_req_t         wr;
	logic            next_aw_held;
	logic            next_w_held;
	wr_req_t         next_wr;
	logic            next_awready;
	logic            next_wready;
	logic [1:0]      next_bresp;
	logic            next_bvalid;
	logic            next_arready;
	logic [31:0]     next_rdata;
	logic [1:0]      next_rresp;
	logic            next_rvalid;
	logic            wr_fire;
	logic            ar_fire;

	// software-visible settings
	logic [7:0]      nco_ctrl;
	logic [3:0]      phase_index;
	upd_mode_t       upd_mode;
	nco_cfg_t        shadow;
	logic [7:0]      next_nco_ctrl;
	logic [3:0]      next_phase_index;
	upd_mode_t       next_upd_mode;
	nco_cfg_t        next_shadow;
	logic            xfer;

	// oscillator state
	nco_cfg_t        chan_cfg [`NUM_CHAN];
	logic [47:0]     acc [`NUM_CHAN];
	nco_cfg_t        next_chan_cfg [`NUM_CHAN];
	logic [3:0]      edge_cnt;
	logic [3:0]      next_edge_cnt;
	logic [3:0]      active;
	logic [47:0]     next_phase;
	logic            gpio_meta;
	logic            gpio_sync;
	logic            gpio_prev;
	logic            gpio_rise;

	function automatic logic [8:0] read_reg(input logic [11:0] idx);
		logic [8:0] r;
		r = 9'h000;
		if (idx == `IDX_NCO_CTRL)
			r = {1'b1, nco_ctrl};
		else if (idx == `IDX_PHASE_CTRL)
			r = {1'b1, 4'h0, phase_index};
		else if (idx == `IDX_UPDATE_CTRL)
			r = {1'b1, 7'h00, upd_mode == UPD_TRANSFER};
		else if (idx == `IDX_STATUS)
			r = {1'b1, 4'h0, active};
		for (int k = 0; k < `NUM_BYTES; k++) begin
			if (idx == TW_IDX[k])
				r = {1'b1, shadow.inc[k*8 +: 8]};
			if (idx == PO_IDX[k])
				r = {1'b1, shadow.off[k*8 +: 8]};
		end
		return r;
	endfunction

	// write side: address and data taken in either order
	always_comb begin
		logic [8:0] wr_map;
		wr_map       = read_reg(wr.idx);
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_wr      = wr;
		next_bresp   = bresp_o;
		next_bvalid  = bvalid_o;
		wr_fire      = aw_held && w_held && !bvalid_o;
		if (bvalid_o && bready_i)
			next_bvalid = 1'b0;
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_map[8] ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (awvalid_i && awready_o) begin
			next_aw_held = 1'b1;
			next_wr.idx  = awaddr_i[`ADDR_W-1:2];
		end
		if (wvalid_i && wready_o) begin
			next_w_held  = 1'b1;
			next_wr.data = wdata_i;
			next_wr.strb = wstrb_i;
		end
		// ready drops while a write is pending so one write at a time
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			wr        <= '0;
			awready_o <= 1'b0;
			wready_o  <= 1'b0;
			bresp_o   <= `RESP_OKAY;
			bvalid_o  <= 1'b0;
		end else begin
			aw_held   <= next_aw_held;
			w_held    <= next_w_held;
			wr        <= next_wr;
			awready_o <= next_awready;
			wready_o  <= next_wready;
			bresp_o   <= next_bresp;
			bvalid_o  <= next_bvalid;
		end
	end

	// read side
	always_comb begin
		logic [8:0] rd;
		rd           = read_reg(araddr_i[`ADDR_W-1:2]);
		ar_fire      = arvalid_i && arready_o;
		next_rvalid  = rvalid_o;
		next_rdata   = rdata_o;
		next_rresp   = rresp_o;
		if (rvalid_o && rready_i)
			next_rvalid = 1'b0;
		if (ar_fire) begin
			next_rvalid = 1'b1;
			next_rdata  = {24'h000000, rd[7:0]};
			next_rresp  = rd[8] ? `RESP_OKAY : `RESP_SLVERR;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			arready_o <= 1'b0;
			rvalid_o  <= 1'b0;
			rdata_o   <= 32'h00000000;
			rresp_o   <= `RESP_OKAY;
		end else begin
			arready_o <= next_arready;
			rvalid_o  <= next_rvalid;
			rdata_o   <= next_rdata;
			rresp_o   <= next_rresp;
		end
	end

	// register writes; only byte lane 0 carries data
	always_comb begin
		logic we;
		we               = wr_fire && wr.strb[0];
		next_nco_ctrl    = nco_ctrl;
		next_phase_index = phase_index;
		next_upd_mode    = upd_mode;
		next_shadow      = shadow;
		xfer             = 1'b0;
		if (we) begin
			if (wr.idx == `IDX_NCO_CTRL)
				next_nco_ctrl = wr.data[7:0];
			if (wr.idx == `IDX_PHASE_CTRL)
				next_phase_index = wr.data[3:0];
			if (wr.idx == `IDX_UPDATE_CTRL) begin
				next_upd_mode = wr.data[`UPD_MODE_BIT] ?
					UPD_TRANSFER : UPD_CONTINUOUS;
				xfer = wr.data[`UPD_XFER_BIT];
			end
			for (int k = 0; k < `NUM_BYTES; k++) begin
				if (wr.idx == TW_IDX[k])
					next_shadow.inc[k*8 +: 8] = wr.data[7:0];
				if (wr.idx == PO_IDX[k])
					next_shadow.off[k*8 +: 8] = wr.data[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			nco_ctrl    <= `RST_BYTE;
			phase_index <= `RST_CHAN;
			upd_mode    <= UPD_CONTINUOUS;
			shadow      <= '0;
		end else begin
			nco_ctrl    <= next_nco_ctrl;
			phase_index <= next_phase_index;
			upd_mode    <= next_upd_mode;
			shadow      <= next_shadow;
		end
	end

	// pin synchroniser; the second stage and its one-cycle delayed copy feed the edge detector
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			gpio_meta <= 1'b0;
			gpio_sync <= 1'b0;
			gpio_prev <= 1'b0;
		end else begin
			gpio_meta <= channel_a_gpio_pin0_i;
			gpio_sync <= gpio_meta;
			gpio_prev <= gpio_sync;
		end
	end

	assign gpio_rise = gpio_sync && !gpio_prev;

	// channel counter for edge-controlled selection
	always_comb begin
		next_edge_cnt = edge_cnt;
		if (nco_ctrl[7:`SEL_MODE_LSB] != `SEL_MODE_EDGE_A)
			next_edge_cnt = `RST_CHAN;
		else if (gpio_rise) begin
			if (edge_cnt >= nco_ctrl[3:0])
				next_edge_cnt = `RST_CHAN;
			else
				next_edge_cnt = edge_cnt + 4'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			edge_cnt <= `RST_CHAN;
		else
			edge_cnt <= next_edge_cnt;
	end

	// other mode codes fall back to the register select field
	assign active = (nco_ctrl[7:`SEL_MODE_LSB] == `SEL_MODE_EDGE_A) ?
		edge_cnt : nco_ctrl[3:0];

	// oscillator bank: every channel free-runs so a switch keeps phase
	for (genvar c = 0; c < `NUM_CHAN; c++) begin : g_accum
		phase_accum #(
			.W (`PHASE_W)
		) u_phase_accum (
			.ref_clk_i (ref_clk_i),
			.srst_i    (srst_i),
			.step_i    (chan_cfg[c].inc),
			.acc_o     (acc[c])
		);
	end

	always_comb begin
		for (int c = 0; c < `NUM_CHAN; c++) begin
			next_chan_cfg[c] = chan_cfg[c];
			if (phase_index == 4'(c) &&
			    (upd_mode == UPD_CONTINUOUS || xfer))
				next_chan_cfg[c] = shadow;
		end
		next_phase = acc[active] + chan_cfg[active].off;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			for (int c = 0; c < `NUM_CHAN; c++) begin
				chan_cfg[c] <= '0;
			end
			nco_phase_o   <= `RST_PHASE;
			nco_channel_o <= `RST_CHAN;
		end else begin
			for (int c = 0; c < `NUM_CHAN; c++) begin
				chan_cfg[c] <= next_chan_cfg[c];
			end
			nco_phase_o   <= next_phase;
			nco_channel_o <= active;
		end
	end

endmodule

// one channel's phase accumulator
module phase_accum #(
	parameter int W = `PHASE_W
) (
	input  wire logic         ref_clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] step_i,
	output logic      [W-1:0] acc_o
);

	logic [W-1:0] next_acc;

	// wraps modulo 2^48, so signed words run backwards
	always_comb begin
		next_acc = acc_o + step_i;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			acc_o <= `RST_PHASE;
		else
			acc_o <= next_acc;
	end

endmodule

// File: hdl/nco_phase_cfg.svh
`ifndef NCO_PHASE_CFG_SVH
`define NCO_PHASE_CFG_SVH

`define ADDR_W          14
`define IDX_W           12
`define PHASE_W         48
`define CHAN_W          4
`define NUM_CHAN        16
`define NUM_BYTES       6

`define IDX_NCO_CTRL    12'h354
`define IDX_PHASE_CTRL  12'h355
`define IDX_TW_BYTE0    12'h356
`define IDX_TW_BYTE1    12'h357
`define IDX_TW_BYTE2    12'h358
`define IDX_TW_BYTE3    12'h359
`define IDX_TW_BYTE4    12'h35a
`define IDX_TW_BYTE5    12'h35b
`define IDX_PO_BYTE0    12'h35d
`define IDX_PO_BYTE1    12'h35e
`define IDX_PO_BYTE2    12'h35f
`define IDX_PO_BYTE3    12'h360
`define IDX_PO_BYTE4    12'h361
`define IDX_PO_BYTE5    12'h362
`define IDX_UPDATE_CTRL 12'h3f0
`define IDX_STATUS      12'h3f1

`define SEL_MODE_LSB    4
`define SEL_MODE_EDGE_A 4'h8
`define UPD_MODE_BIT    0
`define UPD_XFER_BIT    1

`define RST_BYTE        8'h00
`define RST_CHAN        4'h0
`define RST_PHASE       48'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: hdl/nco_phase_pkg.sv
package nco_phase_pkg;

	typedef enum logic {
		UPD_CONTINUOUS,
		UPD_TRANSFER
	} upd_mode_t;

	typedef struct packed {
		logic [47:0] inc;
		logic [47:0] off;
	} nco_cfg_t;

	typedef struct packed {
		logic [11:0] idx;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_req_t;

endpackage

// File: sim/nco_phase_checker.sv
`timescale 1ns/1ps
module nco_phase_checker (
	input wire logic		ref_clk_i,
	input wire logic		srst_i,
	input wire logic		awvalid_i,
	input wire logic		awready_o,
	input wire logic		wvalid_i,
	input wire logic		wready_o,
	input wire logic		bvalid_o,
	input wire logic		bready_i,
	input wire logic		arvalid_i,
	input wire logic		arready_o,
	input wire logic [31:0]	rdata_o,
	input wire logic		rvalid_o,
	input wire logic		rready_i,
	input wire logic [47:0]	nco_phase_o,
	input wire logic [3:0]	nco_channel_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	wr_answer_a: assert property (awvalid_i && awready_o && wvalid_i
		&& wready_o |-> ##[1:2] bvalid_o) else $error("no write answer");
	b_stands_a: assert property (bvalid_o && !bready_i |=> bvalid_o)
		else $error("write answer dropped");
	aw_shut_a: assert property (bvalid_o |-> !awready_o && !wready_o)
		else $error("write taken while answering");
	rd_answer_a: assert property (arvalid_i && arready_o |=> rvalid_o)
		else $error("no read answer");
	r_stands_a: assert property (rvalid_o && !rready_i |=>
		rvalid_o && $stable(rdata_o)) else $error("read answer moved");
	ar_shut_a: assert property (rvalid_o |-> !arready_o)
		else $error("read taken while answering");
	rd_byte_a: assert property (rvalid_o |-> rdata_o[31:8] == 24'h0)
		else $error("read data above low byte");
	rst_zero_a: assert property (disable iff (1'b0) srst_i |=>
		nco_phase_o == 48'h0 && nco_channel_o == 4'h0)
		else $error("oscillator not cleared by reset");
	cover property (bvalid_o && bready_i);
	cover property (rvalid_o && rready_i);
	cover property (nco_channel_o == 4'hf);
endmodule

bind ddc_nco_phase_registers nco_phase_checker u_nco_phase_checker (
	.ref_clk_i, .srst_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o,
	.bvalid_o, .bready_i, .arvalid_i, .arready_o, .rdata_o, .rvalid_o,
	.rready_i, .nco_phase_o, .nco_channel_o);

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "nco_phase_cfg.svh"
module testbench;
	typedef struct packed {
		logic [11:0]	a;
		logic [7:0]		w, r;
		logic [1:0]		s;
	} row_t;
	logic ref_clk_i, srst_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
	logic rready_i, channel_a_gpio_pin0_i, awready_o, wready_o;
	logic bvalid_o, arready_o, rvalid_o;
	logic [`ADDR_W-1:0] awaddr_i, araddr_i;
	logic [31:0] wdata_i, rdata_o;
	logic [3:0] wstrb_i, nco_channel_o;
	logic [1:0] bresp_o, rresp_o, rs, ws;
	logic [47:0] nco_phase_o, p0, v;
	logic [7:0] rd;
	int err_total, samples_checked, cyc;
	// last row hits the hole between the two byte groups
	row_t rows [6] = '{'{12'h355, 8'hff, 8'h0f, 2'h0},
		'{12'h356, 8'ha5, 8'ha5, 2'h0}, '{12'h35b, 8'h81, 8'h81, 2'h0},
		'{12'h35d, 8'h3c, 8'h3c, 2'h0}, '{12'h362, 8'h7e, 8'h7e, 2'h0},
		'{12'h35c, 8'h55, 8'h00, 2'h2}};

	ddc_nco_phase_registers u_ddc_nco_phase_registers (
		.ref_clk_i, .srst_i, .awaddr_i, .awvalid_i, .awready_o,
		.wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o,
		.bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o,
		.rresp_o, .rvalid_o, .rready_i, .channel_a_gpio_pin0_i,
		.nco_phase_o, .nco_channel_o);

	initial begin
		ref_clk_i = 0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	task check(input string n, input logic [47:0] s, e);
		samples_checked++;
		if (s !== e) begin
			$display("unexpected %s exp %h seen %h", n, e, s);
			err_total++;
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		awaddr_i <= {a, 2'b00};
		wdata_i <= {24'h0, d};
		awvalid_i <= 1;
		wvalid_i <= 1;
		bready_i <= 1;
		forever begin
			@(posedge ref_clk_i);
			if (awready_o) awvalid_i <= 0;
			if (wready_o) wvalid_i <= 0;
			if (bvalid_o) break;
		end
		ws = bresp_o;
		bready_i <= 0;
	endtask

	task rd_reg(input logic [11:0] a);
		@(posedge ref_clk_i);
		araddr_i <= {a, 2'b00};
		arvalid_i <= 1;
		rready_i <= 1;
		forever begin
			@(posedge ref_clk_i);
			if (arready_o) arvalid_i <= 0;
			if (rvalid_o) break;
		end
		rd = rdata_o[7:0];
		rs = rresp_o;
		rready_i <= 0;
	endtask

	task wr48(input logic [11:0] a, input logic [47:0] x);
		for (int i = 0; i < 6; i++) wr(a + 12'(i), x[8*i +: 8]);
		tick(4);
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// generous: the whole run needs a few hundred cycles
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up;
		end
	end

	initial begin
		{srst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 6'h20;
		{awaddr_i, araddr_i, wdata_i, channel_a_gpio_pin0_i} = '0;
		wstrb_i = 4'h1;
		repeat (6) @(posedge ref_clk_i);
		srst_i <= 0;
		tick(2);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			check("row wresp", ws, rows[i].s);
			rd_reg(rows[i].a);
			check("row data", rd, rows[i].r);
			check("row resp", rs, rows[i].s);
		end
		$display("table done");
		for (int k = 12; k < 16; k++) begin
			wr(12'h354, 8'(k));
			tick(4);
			check("channel", nco_channel_o, 48'(k));
		end
		$display("select done");
		// negative words with distinct bytes expose lane swaps
		for (int k = 0; k < 4; k++) begin
			wr(12'h354, 8'(k));
			wr(12'h355, 8'(k));
			v = {8'hf0 + 8'(k), 40'h0102030405};
			wr48(12'h356, v);
			p0 = nco_phase_o;
			tick(1);
			check("step", nco_phase_o - p0, v);
		end
		$display("step done");
		wr48(12'h356, 48'h0);
		wr48(12'h35d, 48'h0);
		p0 = nco_phase_o;
		wr48(12'h35d, 48'h8123456789ab);
		check("offset", nco_phase_o - p0, 48'h8123456789ab);
		$display("offset done");
		wr(12'h3f0, 8'h01);
		tick(4);
		p0 = nco_phase_o;
		wr48(12'h35d, 48'h0f1e2d3c4b5a);
		check("held", nco_phase_o, p0);
		wr(12'h3f0, 8'h03);
		tick(4);
		check("xfer", nco_phase_o - p0,
			48'h0f1e2d3c4b5a - 48'h8123456789ab);
		rd_reg(12'h3f0);
		check("mode", rd, 48'h01);
		wr(12'h3f0, 8'h00);
		$display("transfer done");
		wr(12'h354, 8'h82);
		tick(4);
		check("edge", nco_channel_o, 48'h0);
		for (int k = 1; k < 4; k++) begin
			@(posedge ref_clk_i) channel_a_gpio_pin0_i <= 1;
			tick(6);
			check("edge", nco_channel_o, 48'(k % 3));
			rd_reg(12'h3f1);
			check("status", rd, 48'(k % 3));
			@(posedge ref_clk_i) channel_a_gpio_pin0_i <= 0;
			tick(4);
		end
		$display("edge done");
		@(posedge ref_clk_i) srst_i <= 1;
		tick(2);
		check("rst phase", nco_phase_o, 48'h0);
		check("rst chan", nco_channel_o, 48'h0);
		@(posedge ref_clk_i) srst_i <= 0;
		tick(2);
		for (int a = 12'h354; a < 12'h363; a++) begin
			rd_reg(12'(a));
			check("rst reg", rd, 48'h0);
		end
		wstrb_i <= 4'h0;
		wr(12'h355, 8'h05);
		wstrb_i <= 4'h1;
		rd_reg(12'h355);
		check("no lane", rd, 48'h0);
		$display("reset done");
		wrap_up;
	end
endmodule
